// file: inc/lrpfc_pkg.sv
// constants, field positions and state type of the packet controller
package lrpfc_pkg;
	// register map seen over the serial port (7-bit address)
	localparam logic [6:0] TXBUF_BASE = 7'h00;
	localparam logic [6:0] RXBUF_BASE = 7'h30;
	localparam logic [6:0] REG_IRQ = 7'h60;
	localparam logic [6:0] REG_TRIG = 7'h61;
	localparam logic [6:0] REG_TX_RESULT_STATUS = 7'h62;
	localparam logic [6:0] REG_FLUSH = 7'h63;
	localparam logic [6:0] REG_MODE = 7'h64;
	localparam logic [6:0] REG_IFS = 7'h65;
	localparam int BUF_DEPTH = 32;
	// transmit buffer layout, offsets from TXBUF_BASE
	localparam logic [4:0] TX_HDR_LEN_OFS = 5'h00;
	localparam logic [4:0] TX_PKT_LEN_OFS = 5'h01;
	localparam logic [4:0] TX_FC_OFS = 5'h02;
	localparam logic [4:0] TX_SEQ_OFS = 5'h04;
	localparam logic [4:0] TX_DATA_OFS = 5'h05;
	// receive buffer layout, offsets from RXBUF_BASE
	localparam logic [4:0] RX_LEN_OFS = 5'h00;
	localparam logic [4:0] RX_FC_OFS = 5'h01;
	localparam logic [4:0] RX_SEQ_OFS = 5'h03;
	localparam logic [4:0] RX_DATA_OFS = 5'h04;
	// bit positions
	localparam int TRIG_SEND = 0;
	localparam int TRIG_SECURE = 1;
	localparam int TRIG_ACK_REQUEST = 2;
	localparam int TRIG_INDIRECT = 3;
	localparam int TRIG_PEND = 4;
	localparam int TX_RESULT_STATUS_FAIL = 5;
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 3;
	localparam int FL_FLUSH = 0;
	localparam int FL_BCN = 1;
	localparam int FL_DATA = 2;
	localparam int FL_CMD = 3;
	localparam int FL_WREN = 4;
	localparam int MODE_PROMISC = 0;
	localparam int MODE_ERROR = 1;
	localparam int MODE_SRST = 7;
	// reset values
	localparam logic [7:0] IFS_RESET = 8'hA3;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	// frame fields
	localparam logic [2:0] FT_BEACON = 3'h0;
	localparam logic [2:0] FT_DATA = 3'h1;
	localparam logic [2:0] FT_CMD = 3'h3;
	localparam logic [2:0] PREAMBLE_BYTES = 3'h4;
	localparam logic [7:0] SFD_BYTE = 8'hA7;
	localparam logic [7:0] FCS_BYTES = 8'h02;
	localparam logic [7:0] MAX_SIFS_LEN = 8'h12;
	localparam logic [15:0] CRC_POLY_REV = 16'h8408;
	localparam logic [1:0] MAX_RETRY = 2'h3;
	localparam logic [2:0] MAX_CCA_TRIES = 3'h4;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int IFS_UNIT_US = 64;
	localparam int IFS_UNIT_CYC = IFS_UNIT_US * CLK_MHZ;
	localparam int ACK_WAIT_US = 864;
	localparam int ACK_WAIT_CYC_DEF = ACK_WAIT_US * CLK_MHZ;
	// transmit sequencer states
	typedef enum logic [2:0] {TX_IDLE, TX_SPACE, TX_PRE, TX_BODY, TX_FCS,
		TX_END, TX_ACKW, TX_DONE} lrpfc_tx_state_t;
endpackage : lrpfc_pkg

// file: design/lrpfc_top.sv
// packet transmit/receive controller behind a four-wire serial port
`timescale 1ns/1ps
// Function
// RULE1: preamble and delimiter generated by hardware
// RULE2: host writes all other frame bytes
// RULE3: four transmit queues; normal queue held here
// RULE4: spacing, channel check, checksum, resend on missing acknowledge
// RULE5: transmit buffer lengths at 0/1, payload 5
// RULE6: host sets acknowledge request before sending
// RULE7: send bit starts transmission, self clearing
// RULE8: pending bit mirrors last acknowledge, cleared
// RULE9: option bits cleared at next trigger
// RULE10: completion sets done flag and status
// RULE11: status holds retries 7:6, fail bit 5
// RULE12: accepted frame sets receive flag bit 3
// RULE13: single frame buffer, further frames refused
// RULE14: checksum check, type parse, append quality, strength
// RULE15: release by length+last read, flush, soft reset
// RULE16: promiscuous and error receive modes
// RULE17: receive length at 0x30, payload 0x34
// RULE18: flush bit empties buffer, self clearing
// RULE19: frame type filter bits restrict reception
// RULE20: write enable bit gates host buffer writes; here it gates only receive buffer writes, transmit buffer writes are not gated
// RULE21: normal queue released only in contention period
// RULE22: programmable long/short spacing and acknowledge wait
// RULE23: done flag at bit 0 of status
module lrpfc_top #(
	parameter int unsigned ACK_WAIT_CYC = lrpfc_pkg::ACK_WAIT_CYC_DEF
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	output logic [7:0] bb_data,
	output logic bb_valid,
	output logic bb_last,
	input wire logic bb_ready,
	input wire logic cca_busy,
	input wire logic cap_open,
	input wire logic ack_rx,
	input wire logic ack_pend,
	input wire logic rx_sof,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_eof,
	input wire logic rx_fcs_ok,
	input wire logic rx_addr_ok,
	input wire logic [7:0] rx_lqi,
	input wire logic [7:0] rx_rssi
);
	import lrpfc_pkg::*;

	// serial pin synchronisers; stage 1 feeds stage 2 only
	logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, sdi_s1, sdi_s2;
	logic [7:0] sh_in, cmd_reg, wdata_reg, out_sh, rdata;
	logic [3:0] bit_cnt;
	logic wr_stb, rd_stb, sck_rise, sck_fall;
	// register and buffer state
	logic [7:0] tx_mem [BUF_DEPTH];
	logic [7:0] rx_mem [BUF_DEPTH];
	logic [3:0] trig_reg; // send, secure, ack_request, indirect
	logic [7:0] tx_result_status_reg, flush_reg, mode_reg, ifs_reg;
	logic irq_tx_reg, irq_rx_reg;
	// transmit sequencer
	lrpfc_tx_state_t tx_state;
	logic [16:0] tx_cnt;
	logic [4:0] tx_idx;
	logic [7:0] tx_left;
	logic [15:0] crc_reg;
	logic [1:0] retry_reg;
	logic [2:0] tries_reg, pre_cnt;
	logic ack_request_reg, fail_reg, pend_reg, tx_done, tx_start;
	logic [16:0] spacing;
	// receive path
	logic [4:0] rx_idx;
	logic rx_active, rx_lock, got_len, got_fcs, rx_pass, rx_ok;
	logic [2:0] rx_type;
	logic rx_purge, type_ok;
	logic [6:0] a_rx;

	// bytewise reflected checksum update
	function automatic logic [15:0] crc16(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ CRC_POLY_REV;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc16

	// two-flop synchronisers plus one edge stage for the serial clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			{sck_s1, sck_s2, sck_s3} <= 3'h0;
			{cs_s1, cs_s2, sdi_s1, sdi_s2} <= 4'hC;
		end else begin
			{sck_s1, sck_s2, sck_s3} <= {spi_sck, sck_s1, sck_s2};
			{cs_s1, cs_s2} <= {spi_cs_n, cs_s1};
			{sdi_s1, sdi_s2} <= {spi_sdi, sdi_s1};
		end
	end
	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;

	// serial framing: command byte {write, addr[6:0]} then data byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt <= 4'h0;
			sh_in <= 8'h00;
			cmd_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			if (cs_s2) begin
				// deselected: realign on the next command
				bit_cnt <= 4'h0;
			end else if (sck_rise) begin
				sh_in <= {sh_in[6:0], sdi_s2};
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == 4'h7) begin
					cmd_reg <= {sh_in[6:0], sdi_s2};
					rd_stb <= ~sh_in[6];
				end
				if (bit_cnt == 4'hF) begin
					wdata_reg <= {sh_in[6:0], sdi_s2};
					wr_stb <= cmd_reg[7];
				end
			end
		end
	end

	// read data out on falling serial edges, msb first
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			out_sh <= 8'h00;
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else begin
			spi_sdo_oe <= ~cs_s2;
			if (cs_s2) begin
				out_sh <= 8'h00;
			end else if (rd_stb) begin
				out_sh <= rdata;
			end else if (sck_fall) begin
				spi_sdo <= out_sh[7];
				out_sh <= {out_sh[6:0], 1'b0};
			end
		end
	end

	// read multiplexer; unmapped addresses read zero
	assign a_rx = cmd_reg[6:0] - RXBUF_BASE;
	always_comb begin
		rdata = 8'h00;
		if (cmd_reg[6:5] == TXBUF_BASE[6:5]) begin
			rdata = tx_mem[cmd_reg[4:0]];
		end else if (a_rx < 7'(BUF_DEPTH)) begin
			rdata = rx_mem[a_rx[4:0]];
		end else begin
			case (cmd_reg[6:0])
				REG_IRQ: rdata = {4'h0, irq_rx_reg, 2'h0, irq_tx_reg};
				REG_TRIG: rdata = {3'h0, pend_reg, trig_reg[3:1], 1'b0};
				REG_TX_RESULT_STATUS: rdata = tx_result_status_reg;
				REG_FLUSH: rdata = {3'h0, flush_reg[4:0]};
				REG_MODE: rdata = mode_reg;
				REG_IFS: rdata = ifs_reg;
				default: rdata = 8'h00;
			endcase
		end
	end

	// host configuration registers with self-clearing command bits
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			trig_reg <= 4'h0;
			flush_reg <= ZERO_RESET;
			mode_reg <= ZERO_RESET;
			ifs_reg <= IFS_RESET;
		end else begin
			flush_reg[FL_FLUSH] <= 1'b0; // [RULE18]
			mode_reg[MODE_SRST] <= 1'b0;
			if (tx_start) begin
				trig_reg <= 4'h0; // [RULE7] [RULE9]
			end
			if (wr_stb) begin
				case (cmd_reg[6:0])
					REG_TRIG: trig_reg <= wdata_reg[3:0]; // [RULE6]
					REG_FLUSH: flush_reg <= {3'h0, wdata_reg[4:0]};
					REG_MODE: mode_reg <= wdata_reg;
					REG_IFS: ifs_reg <= wdata_reg;
					default: ;
				endcase
			end
		end
	end

	// sticky flags, cleared by reading; a new event wins over the clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_tx_reg <= 1'b0;
			irq_rx_reg <= 1'b0;
		end else begin
			if (tx_done) begin
				irq_tx_reg <= 1'b1; // [RULE10] [RULE23]
			end else if (rd_stb && cmd_reg[6:0] == REG_IRQ) begin
				irq_tx_reg <= 1'b0;
			end
			if (rx_ok) begin
				irq_rx_reg <= 1'b1; // [RULE12]
			end else if (rd_stb && cmd_reg[6:0] == REG_IRQ) begin
				irq_rx_reg <= 1'b0; // [RULE15]
			end
		end
	end

	// transmit buffer storage, written by the host only [RULE2]
	always_ff @(posedge mclk) begin
		if (wr_stb && cmd_reg[6:5] == TXBUF_BASE[6:5]) begin
			tx_mem[cmd_reg[4:0]] <= wdata_reg;
		end
	end

	// only the normal queue lives here, released in the contention period
	assign tx_start = (tx_state == TX_IDLE) && trig_reg[TRIG_SEND]
		&& cap_open; // [RULE3] [RULE21]
	// gap before sending: long for big frames, else short [RULE22]
	assign spacing = (tx_mem[TX_PKT_LEN_OFS] > MAX_SIFS_LEN) ?
		17'(ifs_reg[7:4]) * 17'(IFS_UNIT_CYC) :
		17'(ifs_reg[3:0]) * 17'(IFS_UNIT_CYC);

	// transmit sequencer: spacing, channel check, send, acknowledge wait
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 17'h0;
			tx_idx <= 5'h0;
			tx_left <= 8'h00;
			crc_reg <= 16'h0000;
			retry_reg <= 2'h0;
			tries_reg <= 3'h0;
			pre_cnt <= 3'h0;
			ack_request_reg <= 1'b0;
			fail_reg <= 1'b0;
			pend_reg <= 1'b0;
			tx_done <= 1'b0;
			tx_result_status_reg <= ZERO_RESET;
			bb_data <= 8'h00;
			bb_valid <= 1'b0;
			bb_last <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (bb_ready) begin
				// byte taken by the baseband
				bb_valid <= 1'b0;
				bb_last <= 1'b0;
			end
			case (tx_state)
				TX_IDLE: if (tx_start) begin
					ack_request_reg <= trig_reg[TRIG_ACK_REQUEST];
					pend_reg <= 1'b0; // [RULE8]
					fail_reg <= 1'b0;
					retry_reg <= 2'h0;
					tries_reg <= 3'h0;
					tx_cnt <= spacing;
					tx_state <= TX_SPACE;
				end
				TX_SPACE: if (tx_cnt != 17'h0) begin
					tx_cnt <= tx_cnt - 17'h1;
				end else if (!cap_open) begin
					tx_state <= TX_SPACE; // hold until the period reopens
				end else if (cca_busy) begin
					if (tries_reg == MAX_CCA_TRIES - 3'h1) begin
						fail_reg <= 1'b1; // [RULE4]
						tx_state <= TX_DONE;
					end else begin
						tries_reg <= tries_reg + 3'h1;
						tx_cnt <= spacing;
					end
				end else begin
					pre_cnt <= 3'h0;
					tx_state <= TX_PRE;
				end
				TX_PRE: if (!bb_valid || bb_ready) begin
					bb_valid <= 1'b1;
					pre_cnt <= pre_cnt + 3'h1;
					if (pre_cnt < PREAMBLE_BYTES) begin
						bb_data <= 8'h00; // [RULE1]
					end else if (pre_cnt == PREAMBLE_BYTES) begin
						bb_data <= SFD_BYTE; // [RULE1]
					end else begin
						// length on air counts the checksum [RULE5]
						bb_data <= tx_mem[TX_PKT_LEN_OFS] + FCS_BYTES;
						tx_left <= tx_mem[TX_PKT_LEN_OFS];
						tx_idx <= TX_FC_OFS;
						crc_reg <= 16'h0000;
						tx_state <= TX_BODY;
					end
				end
				TX_BODY: if (!bb_valid || bb_ready) begin
					bb_valid <= 1'b1;
					if (tx_left == 8'h00) begin
						bb_data <= crc_reg[7:0]; // [RULE4]
						tx_state <= TX_FCS;
					end else begin
						bb_data <= tx_mem[tx_idx];
						crc_reg <= crc16(crc_reg, tx_mem[tx_idx]);
						tx_idx <= tx_idx + 5'h1;
						tx_left <= tx_left - 8'h01;
					end
				end
				TX_FCS: if (!bb_valid || bb_ready) begin
					bb_valid <= 1'b1;
					bb_last <= 1'b1;
					bb_data <= crc_reg[15:8];
					tx_state <= TX_END;
				end
				TX_END: if (!bb_valid || bb_ready) begin
					tx_cnt <= 17'(ACK_WAIT_CYC);
					tx_state <= ack_request_reg ? TX_ACKW : TX_DONE;
				end
				TX_ACKW: if (ack_rx) begin
					pend_reg <= ack_pend; // [RULE8]
					tx_state <= TX_DONE;
				end else if (tx_cnt != 17'h0) begin
					tx_cnt <= tx_cnt - 17'h1;
				end else if (retry_reg == MAX_RETRY) begin
					tx_state <= TX_DONE;
				end else begin
					retry_reg <= retry_reg + 2'h1; // [RULE4]
					tries_reg <= 3'h0;
					tx_cnt <= spacing;
					tx_state <= TX_SPACE;
				end
				TX_DONE: begin
					tx_result_status_reg <= {retry_reg, fail_reg, 5'h00}; // [RULE11]
					tx_done <= 1'b1; // [RULE10]
					tx_state <= TX_IDLE;
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// acceptance filter: error mode, promiscuous, then address and type
	assign rx_type = rx_mem[RX_FC_OFS][2:0];
	assign type_ok = !(flush_reg[FL_CMD] && rx_type != FT_CMD)
		&& !(flush_reg[FL_DATA] && rx_type != FT_DATA)
		&& !(flush_reg[FL_BCN] && rx_type != FT_BEACON); // [RULE19]
	assign rx_pass = mode_reg[MODE_ERROR] || (rx_fcs_ok &&
		(mode_reg[MODE_PROMISC] || (rx_addr_ok && type_ok))); // [RULE16]
	assign rx_purge = flush_reg[FL_FLUSH] || mode_reg[MODE_SRST];

	// receive buffer control: fill, lock, release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rx_idx <= 5'h0;
			rx_active <= 1'b0;
			rx_lock <= 1'b0;
			got_len <= 1'b0;
			got_fcs <= 1'b0;
			rx_ok <= 1'b0;
		end else begin
			rx_ok <= 1'b0;
			if (rx_purge) begin
				{rx_active, rx_lock, got_len, got_fcs} <= 4'h0; // [RULE15]
				rx_idx <= 5'h0;
			end else if (rx_lock) begin
				// a held frame blocks reception [RULE13]
				if (rd_stb && a_rx == 7'(RX_LEN_OFS)) begin
					got_len <= 1'b1;
				end
				if (rd_stb && a_rx == 7'(rx_mem[RX_LEN_OFS])) begin
					got_fcs <= 1'b1;
				end
				if (got_len && got_fcs) begin
					{rx_lock, got_len, got_fcs} <= 3'h0; // [RULE15]
				end
			end else if (rx_sof) begin
				rx_active <= 1'b1;
				rx_idx <= RX_LEN_OFS; // [RULE17]
			end else if (rx_active && rx_eof) begin
				rx_active <= 1'b0;
				rx_lock <= rx_pass; // [RULE14]
				rx_ok <= rx_pass;
			end else if (rx_active && rx_valid && rx_idx != 5'h1F) begin
				rx_idx <= rx_idx + 5'h1;
			end
		end
	end

	// receive storage: radio bytes, appended quality bytes, host writes
	always_ff @(posedge mclk) begin
		if (!rx_lock && !rx_purge && rx_active && rx_eof) begin
			rx_mem[rx_idx] <= rx_lqi; // [RULE14]
			rx_mem[5'(rx_idx + 5'h1)] <= rx_rssi; // [RULE14]
		end else if (!rx_lock && !rx_purge && rx_active && rx_valid) begin
			rx_mem[rx_idx] <= rx_byte; // [RULE17]
		end else if (wr_stb && a_rx < 7'(BUF_DEPTH)
			&& flush_reg[FL_WREN]) begin
			rx_mem[a_rx[4:0]] <= wdata_reg; // [RULE20]
		end
	end
endmodule : lrpfc_top

// file: test/lrpfc_monitor.sv
// checker of the outgoing stream and the serial select pins
`timescale 1ns/1ps
module lrpfc_monitor (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic spi_cs_n,
	input wire logic spi_sdo_oe,
	input wire logic [7:0] bb_data,
	input wire logic bb_valid,
	input wire logic bb_last,
	input wire logic bb_ready,
	input wire logic cca_busy
);
	import lrpfc_pkg::*;
	logic [7:0] byte_idx; // bytes taken so far in this frame
	logic [7:0] len_reg; // length byte of this frame
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// position within the outgoing frame
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			byte_idx <= 8'h00;
			len_reg <= 8'h00;
		end else if (bb_valid && bb_ready) begin
			byte_idx <= bb_last ? 8'h00 : byte_idx + 8'h01;
			if (byte_idx == 8'h05) len_reg <= bb_data;
		end
	end
	property p_bb_hold;
		bb_valid && !bb_ready |=>
			bb_valid && $stable(bb_data) && $stable(bb_last);
	endproperty
	a_bb_hold: assert property (p_bb_hold)
		else $error("stream byte changed before it was taken");
	property p_preamble;
		bb_valid && byte_idx < 8'h04 |-> bb_data == 8'h00;
	endproperty
	a_preamble: assert property (p_preamble)
		else $error("preamble byte not zero");
	property p_sfd;
		bb_valid && byte_idx == 8'h04 |-> bb_data == SFD_BYTE;
	endproperty
	a_sfd: assert property (p_sfd)
		else $error("delimiter byte wrong");
	property p_last_pos;
		bb_valid && bb_last |-> byte_idx == len_reg + 8'h05;
	endproperty
	a_last_pos: assert property (p_last_pos)
		else $error("frame end does not match its length byte");
	property p_early_last;
		bb_valid && byte_idx < 8'h06 |-> !bb_last;
	endproperty
	a_early_last: assert property (p_early_last)
		else $error("frame ended inside its header");
	property p_busy_hold;
		(cca_busy && !bb_valid && byte_idx == 8'h00) [*8] |=> !bb_valid;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("frame started on a busy channel");
	property p_oe_on;
		!spi_cs_n [*6] |-> spi_sdo_oe;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("serial output not driven while selected");
	property p_oe_off;
		spi_cs_n [*6] |-> !spi_sdo_oe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("serial output driven while deselected");
endmodule : lrpfc_monitor

// file: test/lrpfc_host_model.sv
// host model: one serial register access at a time
`timescale 1ns/1ps
module lrpfc_host_model (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_sdi,
	input wire logic spi_sdo
);
	// link idles with select high and clock low
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// command byte then data, msb first; read bit taken before the fall
	task automatic xfer(input logic wr, input logic [6:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [15:0] sh;
		sh = {wr, a, d};
		// step off the clock edge the caller stands on
		#1 spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_sdi = sh[i];
			#40 spi_sck = 1'b1;
			#39;
			if (i < 8) q[i] = spi_sdo;
			#1 spi_sck = 1'b0;
		end
		#40 spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line shows no stale bit
		// keeps each access at 1440 ns so callers stay in step
		#119;
	endtask : xfer
endmodule : lrpfc_host_model

// file: test/test_lrpfc_top.sv
// self-checking bench of the packet controller
`timescale 1ns/1ps
module test_lrpfc_top;
	import lrpfc_pkg::*;
	logic mclk, resetn, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
	logic [7:0] bb_data, rx_byte, rx_lqi, rx_rssi, got;
	logic bb_valid, bb_last, bb_ready, cca_busy, cap_open, ack_rx, ack_pend;
	logic rx_sof, rx_valid, rx_eof, rx_fcs_ok, rx_addr_ok;
	logic [7:0] exp_q[$], bb_q[$], fr[8]; // expected reads, stream, frame
	int error_cnt = 0, n_tests = 0, n_last = 0;
	event rd_ev; // a register read has landed
	lrpfc_top #(.ACK_WAIT_CYC(50)) lrpfc_top_i (.mclk, .resetn, .spi_sck,
		.spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .bb_data, .bb_valid,
		.bb_last, .bb_ready, .cca_busy, .cap_open, .ack_rx, .ack_pend,
		.rx_sof, .rx_valid, .rx_byte, .rx_eof, .rx_fcs_ok, .rx_addr_ok,
		.rx_lqi, .rx_rssi);
	lrpfc_host_model lrpfc_host_model_i (.spi_sck, .spi_cs_n, .spi_sdi,
		.spi_sdo);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// register read comparison
	task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] register expected %h seen %h", e, g);
		end
	endtask : chk_reg
	// outgoing stream byte comparison
	task automatic chk_stream(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] stream expected %h seen %h", e, g);
		end
	endtask : chk_stream
	// counts, verdict and end of run
	task wrap_up;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] u;
		lrpfc_host_model_i.xfer(1'b1, a, d, u);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		lrpfc_host_model_i.xfer(1'b0, a, 8'h00, got);
		->rd_ev;
	endtask : rd
	// poll the flags until one shows, then compare
	task automatic wait_irq(input logic [7:0] e);
		int n;
		n = 0;
		got = 8'h00;
		while (got === 8'h00 && n < 1000) begin
			lrpfc_host_model_i.xfer(1'b0, REG_IRQ, 8'h00, got);
			n++;
		end
		exp_q.push_back(e);
		->rd_ev;
	endtask : wait_irq
	// load a random frame, note its stream reps times, then trigger
	task automatic tx_frame(input logic [7:0] trig, input int reps);
		logic [7:0] b[$];
		logic [7:0] n;
		logic [15:0] c;
		n = 8'h03 + 8'($urandom % 4);
		c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			b.push_back(8'($urandom) | ((i == 0 && trig[2]) ? 8'h20 : 8'h00));
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY_REV : c >> 1;
			wr(7'(2 + i), b[i]);
		end
		wr(7'h00, 8'h03);
		wr(7'h01, n);
		repeat (reps) begin
			repeat (4) bb_q.push_back(8'h00);
			bb_q.push_back(SFD_BYTE);
			bb_q.push_back(n + FCS_BYTES);
			foreach (b[i]) bb_q.push_back(b[i]);
			bb_q.push_back(c[7:0]);
			bb_q.push_back(c[15:8]);
		end
		wr(REG_TRIG, trig);
	endtask : tx_frame
	// one received frame of seven bytes after its length byte
	task automatic rx_frame(input logic [2:0] ft, input logic ok,
		input logic ad);
		foreach (fr[i]) fr[i] = 8'($urandom);
		fr[0] = 8'h07;
		fr[1] = {5'h00, ft};
		rx_lqi = 8'($urandom);
		rx_rssi = 8'($urandom);
		@(posedge mclk) #1 rx_sof = 1'b1;
		foreach (fr[i]) begin
			@(posedge mclk) #1 rx_sof = 1'b0;
			rx_valid = 1'b1;
			rx_byte = fr[i];
			@(posedge mclk) #1 rx_valid = 1'b0;
		end
		rx_fcs_ok = ok;
		rx_addr_ok = ad;
		rx_eof = 1'b1;
		@(posedge mclk) #1 rx_eof = 1'b0;
		rx_fcs_ok = ~ok;
		rx_addr_ok = ~ad;
		repeat (4) @(posedge mclk);
	endtask : rx_frame
	// read results against the oldest note
	always @(rd_ev) chk_reg(exp_q.pop_front(), got);
	// stream results, and an acknowledge after the second frame
	always @(posedge mclk) begin
		if (bb_valid === 1'b1 && bb_ready === 1'b1) begin
			chk_stream(bb_q.size() ? bb_q.pop_front() : 8'hXX, bb_data);
			if (bb_last === 1'b1 && ++n_last == 2) begin
				repeat (5) @(posedge mclk);
				#1 ack_rx = 1'b1;
				ack_pend = 1'b1;
				@(posedge mclk) #1 ack_rx = 1'b0;
				ack_pend = 1'b0;
			end
		end
	end
	always @(posedge mclk) #1 bb_ready = 1'($urandom % 4 != 0);
	initial begin
		#1000000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		logic [7:0] s1;
		logic [7:0] f1;
		void'($urandom(32'h2B88AABC));
		{resetn, cca_busy, ack_rx, ack_pend, rx_sof, rx_valid} = 6'h00;
		{rx_eof, rx_fcs_ok, rx_addr_ok, bb_ready, cap_open} = 5'h01;
		{rx_byte, rx_lqi, rx_rssi} = 24'h000000;
		repeat (20) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge mclk);
		rd(REG_IRQ, ZERO_RESET);
		rd(REG_TRIG, ZERO_RESET);
		rd(REG_TX_RESULT_STATUS, ZERO_RESET);
		rd(REG_FLUSH, ZERO_RESET);
		rd(REG_IFS, IFS_RESET);
		rd(7'h7F, ZERO_RESET);
		wr(REG_IFS, 8'h11);
		tx_frame(8'h0F, 2);
		wait_irq(8'h01);
		rd(REG_TX_RESULT_STATUS, 8'h40);
		rd(REG_TRIG, 8'h10);
		// closed contention period holds the trigger
		@(posedge mclk) #1 cap_open = 1'b0;
		tx_frame(8'h03, 1);
		rd(REG_TRIG, 8'h12);
		@(posedge mclk) #1 cap_open = 1'b1;
		wait_irq(8'h01);
		rd(REG_TRIG, 8'h00);
		rd(REG_TX_RESULT_STATUS, 8'h00);
		@(posedge mclk) #1 cca_busy = 1'b1;
		tx_frame(8'h01, 0);
		wait_irq(8'h01);
		rd(REG_TX_RESULT_STATUS, 8'h20);
		@(posedge mclk) #1 cca_busy = 1'b0;
		rx_frame(FT_DATA, 1'b1, 1'b1);
		wait_irq(8'h08);
		rd(7'h33, fr[3]);
		rd(7'h34, fr[4]);
		rd(7'h38, rx_lqi);
		rd(7'h39, rx_rssi);
		wr(7'h33, ~fr[3]);
		rd(7'h33, fr[3]);
		s1 = fr[3];
		f1 = fr[7];
		rx_frame(FT_DATA, 1'b1, 1'b1);
		rd(REG_IRQ, 8'h00);
		rd(7'h33, s1);
		rd(7'h30, 8'h07);
		rd(7'h37, f1);
		rx_frame(FT_DATA, 1'b1, 1'b1);
		wait_irq(8'h08);
		wr(REG_FLUSH, 8'h10);
		wr(7'h33, 8'h5A);
		rd(7'h33, 8'h5A);
		wr(REG_FLUSH, 8'h01);
		rd(REG_FLUSH, 8'h00);
		for (int k = 1; k < 4; k++) begin
			wr(REG_FLUSH, 8'(1 << k));
			rx_frame(k == 2 ? FT_CMD : FT_DATA, 1'b1, 1'b1);
			rd(REG_IRQ, 8'h00);
			rx_frame(k == 1 ? FT_BEACON : k == 2 ? FT_DATA : FT_CMD, 1'b1, 1'b1);
			wait_irq(8'h08);
			wr(REG_FLUSH, 8'((1 << k) | 1));
			rd(REG_FLUSH, 8'(1 << k));
		end
		wr(REG_FLUSH, 8'h00);
		for (int m = 0; m < 2; m++) begin
			rx_frame(FT_DATA, 1'(m), 1'b0);
			rd(REG_IRQ, 8'h00);
			wr(REG_MODE, 8'(1 << (1 - m)));
			rx_frame(FT_DATA, 1'(m), 1'b0);
			wait_irq(8'h08);
			wr(REG_MODE, 8'h00);
			// release by flush first, then by soft reset
			if (m == 0) begin
				wr(REG_FLUSH, 8'h01);
			end else begin
				wr(REG_MODE, 8'h80);
			end
		end
		rx_frame(FT_DATA, 1'b1, 1'b1);
		wait_irq(8'h08);
		rd(REG_MODE, 8'h00);
		// every noted stream byte must have been sent
		chk_stream(8'h00, 8'(bb_q.size()));
		wrap_up();
	end
endmodule : test_lrpfc_top
bind lrpfc_top lrpfc_monitor lrpfc_monitor_i (.mclk, .resetn, .spi_cs_n,
	.spi_sdo_oe, .bb_data, .bb_valid, .bb_last, .bb_ready, .cca_busy);
